/* File: mcc_config_regs.sv */
// Compensation, memory clock delay and capability id registers on classic Wishbone.
// Assumes live codes from the compensation engine arrive on the same clock.
`include "mcc_defines.svh"

module mcc_config_regs
  import mcc_pkg::*;
#(
  parameter int TAP_COUNT = `MCC_TAP_COUNT
) (
  input wire logic ref_clk_in, // System clock, 25 MHz
  input wire logic sys_rst_in, // Synchronous reset, high
  input wire logic wb_cyc_in, // Wishbone cycle
  input wire logic wb_stb_in, // Wishbone strobe
  input wire logic wb_we_in, // Wishbone write enable
  input wire logic [7:0] wb_adr_in, // Wishbone byte address
  input wire logic [31:0] wb_dat_in, // Wishbone write data
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects
  output logic [31:0] wb_dat_out, // Wishbone read data
  output logic wb_ack_out, // Wishbone acknowledge
  input wire logic graphics_mode_in, // Device in graphics-port mode
  input wire mcc_code_pair_type vert_live_code_in, // Automatic vertical codes
  input wire mcc_code_pair_type horiz_live_code_in, // Automatic horizontal codes
  output mcc_code_pair_type vertical_code_out, // Applied vertical codes
  output mcc_code_pair_type horizontal_code_out, // Applied horizontal codes
  output logic vertical_comp_run_out, // Vertical automatic compensation runs
  output logic horizontal_comp_run_out, // Horizontal automatic compensation runs
  output logic transmit_delay_loop_enable_out, // Transmit loop enabled
  output logic transmit_delay_loop_bypass_out, // Memory clock routed around loop
  output logic receive_delay_loop_bypass_out, // Receive loop bypassed
  output logic [2:0] receive_tap_select_out // Receive delay chain tap, 0 is no delay
);

  // Tap select port is three bits wide: only eight taps fit
  if (TAP_COUNT != `MCC_TAP_COUNT) begin : g_tap_check
    $error("TAP_COUNT must be 8");
  end

  localparam int ORIENTS = 2;
  localparam int LANES = 4;

  mcc_bus_state_type bus_state;
  mcc_bus_state_type next_bus_state;
  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  mcc_sel_type sel;
  logic req;
  logic wr_take;
  logic [LANES-1:0] lane_wr;
  logic comp_wr;
  logic clk_wr;
  logic tap_wr;
  logic transmit_dll_bypass;
  logic next_transmit_dll_bypass;
  logic transmit_dll_enable;
  logic next_transmit_dll_enable;
  logic [2:0] rx_tap;
  logic [2:0] next_rx_tap;
  mcc_orient_type orient_state [ORIENTS];
  mcc_code_pair_type live_code [ORIENTS];
  logic [ORIENTS-1:0] comp_run;
  mcc_code_pair_type vertical_code;
  mcc_code_pair_type next_vertical_code;
  mcc_code_pair_type horizontal_code;
  mcc_code_pair_type next_horizontal_code;
  logic [31:0] read_word;
  logic [31:0] comp_word;
  logic [31:0] clk_word;
  logic [31:0] capid_word;

  // Address decode; capability id hidden outside graphics mode
  always_comb begin
    unique case (wb_adr_in)
      `MCC_OFS_COMP: sel = MCC_SEL_COMP;
      `MCC_OFS_CLK: sel = MCC_SEL_CLK;
      `MCC_OFS_CAPID: sel = graphics_mode_in ? MCC_SEL_CAPID : MCC_SEL_NONE;
      default: sel = MCC_SEL_NONE;
    endcase
  end

  assign req = wb_cyc_in & wb_stb_in & (bus_state == MCC_BUS_IDLE);
  assign wr_take = req & wb_we_in;

  // One write strobe per byte lane
  for (genvar b = 0; b < LANES; b++) begin : g_lane
    assign lane_wr[b] = wr_take & wb_sel_in[b];
  end

  // Override and code fields sit in bytes 3, 2, 1 and 0
  assign comp_wr = (sel == MCC_SEL_COMP) & (&lane_wr);
  assign clk_wr = (sel == MCC_SEL_CLK) & lane_wr[1];
  assign tap_wr = (sel == MCC_SEL_CLK) & lane_wr[0];

  // Orientation 0 is vertical, 1 horizontal; each runs on its own
  assign live_code[0] = vert_live_code_in;
  assign live_code[1] = horiz_live_code_in;

  for (genvar o = 0; o < ORIENTS; o++) begin : g_orient
    localparam int OVR_BIT = (o == 0) ? `MCC_BIT_V_OVR : `MCC_BIT_H_OVR;
    localparam int PSIDE_LO = (o == 0) ? `MCC_VP_LO : `MCC_HP_LO;
    localparam int NSIDE_LO = (o == 0) ? `MCC_VN_LO : `MCC_HN_LO;
    mcc_orient_ctrl u_orient (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_in(comp_wr),
      .override_wr_in(wb_dat_in[OVR_BIT]),
      .code_wr_in({wb_dat_in[PSIDE_LO +: 3], wb_dat_in[NSIDE_LO +: 3]}),
      .live_code_in(live_code[o]),
      .state_out(orient_state[o]),
      .comp_run_out(comp_run[o])
    );
  end

  assign vertical_comp_run_out = comp_run[0];
  assign horizontal_comp_run_out = comp_run[1];

  // Read words; reserved bits zero
  always_comb begin
    comp_word = 32'h0000_0000;
    comp_word[`MCC_BIT_V_OVR] = orient_state[0].override;
    comp_word[`MCC_VP_HI:`MCC_VP_LO] = orient_state[0].code.pside;
    comp_word[`MCC_VN_HI:`MCC_VN_LO] = orient_state[0].code.nside;
    comp_word[`MCC_BIT_H_OVR] = orient_state[1].override;
    comp_word[`MCC_HP_HI:`MCC_HP_LO] = orient_state[1].code.pside;
    comp_word[`MCC_HN_HI:`MCC_HN_LO] = orient_state[1].code.nside;
  end

  always_comb begin
    clk_word = 32'h0000_0000;
    clk_word[`MCC_BIT_TX_BYP] = transmit_dll_bypass;
    clk_word[2:0] = rx_tap;
  end

  assign capid_word = {8'h00, `MCC_CAP_MAJOR, `MCC_CAP_MINOR, `MCC_CAP_NEXT, `MCC_CAP_TYPE};

  // Clock control: transmit bypass and receive tap
  always_comb begin
    next_transmit_dll_bypass = transmit_dll_bypass;
    next_rx_tap = rx_tap;
    if (clk_wr) begin
      next_transmit_dll_bypass = wb_dat_in[`MCC_BIT_TX_BYP];
    end
    if (tap_wr) begin
      next_rx_tap = wb_dat_in[2:0];
    end
    next_transmit_dll_enable = ~next_transmit_dll_bypass;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      transmit_dll_bypass <= 1'b0;
      transmit_dll_enable <= 1'b1;
      rx_tap <= `MCC_TAP_RESET;
    end else begin
      transmit_dll_bypass <= next_transmit_dll_bypass;
      transmit_dll_enable <= next_transmit_dll_enable;
      rx_tap <= next_rx_tap;
    end
  end

  // Read word of the addressed register; holes read zero
  always_comb begin
    unique case (sel)
      MCC_SEL_COMP: read_word = comp_word;
      MCC_SEL_CLK: read_word = clk_word;
      MCC_SEL_CAPID: read_word = capid_word;
      MCC_SEL_NONE: read_word = 32'h0000_0000;
    endcase
  end

  // Bus slave: ack one cycle after the request, then one idle cycle
  always_comb begin
    next_bus_state = bus_state;
    next_rd_data = rd_data;
    unique case (bus_state)
      MCC_BUS_IDLE: begin
        if (req) begin
          next_bus_state = MCC_BUS_ACK;
          next_rd_data = read_word;
        end
      end
      MCC_BUS_ACK: begin
        next_bus_state = MCC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bus_state <= MCC_BUS_IDLE;
      rd_data <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      rd_data <= next_rd_data;
    end
  end

  assign wb_ack_out = (bus_state == MCC_BUS_ACK);
  assign wb_dat_out = rd_data;

  // Applied codes leave through flops; no reset, they follow the mux
  always_comb begin
    next_vertical_code = orient_state[0].code;
    next_horizontal_code = orient_state[1].code;
  end

  always_ff @(posedge ref_clk_in) begin
    vertical_code <= next_vertical_code;
    horizontal_code <= next_horizontal_code;
  end

  assign vertical_code_out = vertical_code;
  assign horizontal_code_out = horizontal_code;
  assign transmit_delay_loop_enable_out = transmit_dll_enable;
  assign transmit_delay_loop_bypass_out = transmit_dll_bypass;
  assign receive_delay_loop_bypass_out = 1'b1;
  assign receive_tap_select_out = rx_tap;

endmodule

/* File: mcc_config_regs_properties.sv */
// Port assertions for the compensation config registers.
// Assumes binding onto mcc_config_regs.
module mcc_config_regs_properties
  import mcc_pkg::*;
#(
  parameter int TAP_COUNT = 8
) (
  input wire logic ref_clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic wb_cyc_in, // Cycle
  input wire logic wb_stb_in, // Strobe
  input wire logic wb_we_in, // Write
  input wire logic [7:0] wb_adr_in, // Address
  input wire logic [31:0] wb_dat_in, // Write data
  input wire logic [3:0] wb_sel_in, // Selects
  input wire logic [31:0] wb_dat_out, // Read data
  input wire logic wb_ack_out, // Ack
  input wire logic graphics_mode_in, // Graphics mode
  input wire mcc_code_pair_type vert_live_code_in, // Live V
  input wire mcc_code_pair_type horiz_live_code_in, // Live H
  input wire mcc_code_pair_type vertical_code_out, // Applied V
  input wire mcc_code_pair_type horizontal_code_out, // Applied H
  input wire logic vertical_comp_run_out, // V auto
  input wire logic horizontal_comp_run_out, // H auto
  input wire logic transmit_delay_loop_enable_out, // Tx on
  input wire logic transmit_delay_loop_bypass_out, // Tx bypass
  input wire logic receive_delay_loop_bypass_out, // Rx bypass
  input wire logic [2:0] receive_tap_select_out // Tap
);
  logic take;
  logic cwr;
  assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign cwr = take && wb_we_in && wb_adr_in == 8'h98 && wb_sel_in == 4'hf;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ack_latency: assert property (take |=> wb_ack_out)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_vert_live: assert property ($past(vertical_comp_run_out) |-> vertical_code_out == $past(vert_live_code_in))
    else $error("vertical code not live");
  a_horiz_live: assert property ($past(horizontal_comp_run_out)
    |-> horizontal_code_out == $past(horiz_live_code_in))
    else $error("horizontal code not live");
  a_vert_override: assert property (cwr && wb_dat_in[31] |=> !vertical_comp_run_out)
    else $error("vertical override not taken");
  a_horiz_override: assert property (cwr && wb_dat_in[15] |=> !horizontal_comp_run_out)
    else $error("horizontal override not taken");
  a_tx_inverse: assert property (transmit_delay_loop_enable_out != transmit_delay_loop_bypass_out)
    else $error("transmit enable and bypass agree");
  a_rx_bypass: assert property (receive_delay_loop_bypass_out)
    else $error("receive loop not bypassed");
  a_reset_state: assert property ($fell(sys_rst_in) |-> transmit_delay_loop_enable_out &&
    vertical_comp_run_out && horizontal_comp_run_out && receive_tap_select_out == 3'h0)
    else $error("wrong state after reset");
  a_capid_read: assert property (take && !wb_we_in && wb_adr_in == 8'ha0 && graphics_mode_in
    |=> wb_dat_out == 32'h0020_0002)
    else $error("capability id wrong");
  a_unmapped_zero: assert property (take && !wb_we_in && wb_adr_in == 8'h50 |=> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

bind mcc_config_regs mcc_config_regs_properties #(.TAP_COUNT(TAP_COUNT)) chk (.*);

/* File: mcc_defines.svh */
// Offsets, field positions, reset values and fixed codes of the compensation config block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH

`define MCC_OFS_COMP 8'h98
`define MCC_OFS_CLK 8'h9c
`define MCC_OFS_CAPID 8'ha0

`define MCC_BIT_V_OVR 31
`define MCC_BIT_H_OVR 15
`define MCC_VP_HI 22
`define MCC_VP_LO 20
`define MCC_VN_HI 18
`define MCC_VN_LO 16
`define MCC_HP_HI 6
`define MCC_HP_LO 4
`define MCC_HN_HI 2
`define MCC_HN_LO 0
`define MCC_BIT_TX_BYP 15

`define MCC_CAP_MAJOR 4'h2
`define MCC_CAP_MINOR 4'h0
`define MCC_CAP_NEXT 8'h00
`define MCC_CAP_TYPE 8'h02
`define MCC_CAPID_RESET 32'h0020_0002

`define MCC_CODE_RESET 3'h0
`define MCC_TAP_RESET 3'h0
`define MCC_TAP_COUNT 8

`endif

/* File: mcc_orient_ctrl.sv */
// One orientation's compensation override: picks live or software codes.
// Assumes a same-clock live code input and a write strobe from the register slave.
`include "mcc_defines.svh"

module mcc_orient_ctrl
  import mcc_pkg::*;
(
  input wire logic ref_clk_in, // System clock
  input wire logic sys_rst_in, // Synchronous reset, high
  input wire logic wr_in, // Register write taken this cycle
  input wire logic override_wr_in, // Written override bit
  input wire mcc_code_pair_type code_wr_in, // Written codes
  input wire mcc_code_pair_type live_code_in, // Codes from the automatic engine
  output mcc_orient_type state_out, // Override bit and applied codes
  output logic comp_run_out // Automatic compensation runs
);

  logic override;
  logic next_override;
  mcc_code_pair_type sw_code;
  mcc_code_pair_type next_sw_code;

  always_comb begin
    next_override = override;
    next_sw_code = sw_code;
    if (wr_in) begin
      next_override = override_wr_in;
      // Codes only land while override already holds
      if (override) begin
        next_sw_code = code_wr_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      override <= 1'b0;
      sw_code <= {`MCC_CODE_RESET, `MCC_CODE_RESET};
    end else begin
      override <= next_override;
      sw_code <= next_sw_code;
    end
  end

  assign comp_run_out = ~override;
  assign state_out.override = override;
  // Live codes while automatic, written codes while overridden
  assign state_out.code = override ? sw_code : live_code_in;

endmodule

/* File: mcc_pkg.sv */
// Types shared by the compensation config block.
// Assumes mcc_defines.svh for the numeric constants.
package mcc_pkg;

  typedef struct packed {
    logic [2:0] pside;
    logic [2:0] nside;
  } mcc_code_pair_type;

  typedef struct packed {
    logic override;
    mcc_code_pair_type code;
  } mcc_orient_type;

  typedef enum logic [1:0] {
    MCC_SEL_COMP,
    MCC_SEL_CLK,
    MCC_SEL_CAPID,
    MCC_SEL_NONE
  } mcc_sel_type;

  typedef enum {
    MCC_BUS_IDLE,
    MCC_BUS_ACK
  } mcc_bus_state_type;

endpackage

/* File: testbench.sv */
// Self-checking bench for the compensation config registers.
// Assumes the design files and the checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mcc_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, gm = 1, ack, vr, hr, te, tb, rb;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0000_0000, rd;
  logic [2:0] tap;
  mcc_code_pair_type lv = 6'h00, lh = 6'h00, sv, sh, vo, ho;
  logic [31:0] exp_q[$];
  int bad_count = 0, compares = 0, cycles = 0;
  initial forever #20 clk = ~clk;
  mcc_config_regs dut (.ref_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(rd), .wb_ack_out(ack),
    .graphics_mode_in(gm), .vert_live_code_in(lv), .horiz_live_code_in(lh), .vertical_code_out(vo),
    .horizontal_code_out(ho), .vertical_comp_run_out(vr), .horizontal_comp_run_out(hr),
    .transmit_delay_loop_enable_out(te), .transmit_delay_loop_bypass_out(tb),
    .receive_delay_loop_bypass_out(rb), .receive_tap_select_out(tap));
  task automatic conclude();
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    if (!w) exp_q.push_back(e);
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  function automatic logic [31:0] comp(mcc_code_pair_type v, mcc_code_pair_type h, logic ov, logic oh);
    return {ov, 8'h00, v.pside, 1'b0, v.nside, oh, 8'h00, h.pside, 1'b0, h.nside};
  endfunction
  // Read data is compared against the oldest expectation
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      check("read data", rd, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h351e8b36));
    repeat (12) @(posedge clk);
    rst <= 0;
    lv <= 6'($urandom);
    lh <= 6'($urandom);
    sv = 6'($urandom);
    sh = 6'($urandom);
    @(posedge clk);
    bus(0, 8'h98, 0, comp(lv, lh, 0, 0));
    bus(0, 8'h9c, 0, 0);
    bus(1, 8'ha0, 32'hffff_ffff, 0);
    bus(0, 8'ha0, 0, 32'h0020_0002);
    gm <= 0;
    bus(0, 8'ha0, 0, 0);
    bus(0, 8'h50, 0, 0);
    bus(1, 8'h98, comp(sv, sh, 0, 0), 0);
    bus(0, 8'h98, 0, comp(lv, lh, 0, 0));
    bus(1, 8'h98, 32'h8000_0000, 0);
    bus(0, 8'h98, 0, comp(6'h00, lh, 1, 0));
    bus(1, 8'h98, comp(sv, sh, 1, 0), 0);
    sel <= 4'h7;
    bus(1, 8'h98, comp(~sv, sh, 1, 0), 0);
    sel <= 4'hf;
    bus(0, 8'h98, 0, comp(sv, lh, 1, 0));
    check("vertical code", vo, sv);
    check("horizontal code", ho, lh);
    check("vertical run", vr, 0);
    check("horizontal run", hr, 1);
    bus(1, 8'h98, 32'h0000_8000, 0);
    bus(1, 8'h98, comp(sv, sh, 0, 1), 0);
    bus(0, 8'h98, 0, comp(lv, sh, 0, 1));
    check("horizontal code", ho, sh);
    check("vertical code", vo, lv);
    check("horizontal run", hr, 0);
    check("vertical run", vr, 1);
    bus(1, 8'h9c, 32'hffff_ffff, 0);
    bus(0, 8'h9c, 0, 32'h0000_8007);
    check("tx bypass", tb, 1);
    check("tx enable", te, 0);
    check("rx bypass", rb, 1);
    for (int i = 0; i < 8; i++) begin
      bus(1, 8'h9c, i, 0);
      check("tap", tap, i);
    end
    check("tx enable", te, 1);
    conclude();
  end
endmodule
